// ===== verilog/trm_pkg.sv
// Constants, carriers and decode helpers for the transceiver register map.
// Assumes a byte-wide register space and one 100 MHz clock.
//
// Functional notes
// - Serial mode decodes addresses 09 to 23.
// - Self-load mode reaches only addresses 0A to 1C.
// - Reset key and shutdown timer hidden in self-load.
// - Addresses 1E to 23 are read-only monitors.
// - Addresses 09 to 1D read back written value.
// - One-byte address selects each register.
// - Every register holds eight data bits.
// - Address 1E reports detection and lock status.
// - Address 1F reports the peak-hold level.
// - Addresses 20 and 21 report comparator status.
// - Address 22 strength level, 23 noise level.
// - Address 1D holds shutdown duration, serial only.
// - Writing 01010101 to 09 restores initial values.
// - Enable bit or pins select sleep; activity bit selects standby or run.

package trm_pkg;

    // Widths and sizes
    localparam int TRM_DATA_W = 8;
    localparam int TRM_ADDR_W = 8;
    localparam int TRM_MEM_DEPTH = 21;
    localparam int TRM_IDX_W = 5;

    // Register addresses
    localparam logic [7:0] TRM_ADDR_SOFT_RESET_KEY = 8'h09;
    localparam logic [7:0] TRM_ADDR_GENERAL_SETTINGS = 8'h0a;
    localparam logic [7:0] TRM_ADDR_LOCAL_FREQ_LOW = 8'h0b;
    localparam logic [7:0] TRM_ADDR_LOCAL_FREQ_HIGH = 8'h0c;
    localparam logic [7:0] TRM_ADDR_DELAY_DRIVE_CFG = 8'h0d;
    localparam logic [7:0] TRM_ADDR_RX_FRONT_END_CFG = 8'h0e;
    localparam logic [7:0] TRM_ADDR_RX_FUNCTION_CFG_A = 8'h0f;
    localparam logic [7:0] TRM_ADDR_RX_FUNCTION_CFG_B = 8'h10;
    localparam logic [7:0] TRM_ADDR_FAST_CHARGE_THRESHOLD = 8'h11;
    localparam logic [7:0] TRM_ADDR_TX_DEVIATION_CFG = 8'h12;
    localparam logic [7:0] TRM_ADDR_TX_AMP_CFG = 8'h13;
    localparam logic [7:0] TRM_ADDR_MONITOR_SELECT_A = 8'h14;
    localparam logic [7:0] TRM_ADDR_MONITOR_SELECT_B = 8'h15;
    localparam logic [7:0] TRM_ADDR_STRENGTH_THRESHOLD = 8'h16;
    localparam logic [7:0] TRM_ADDR_PREAMBLE_CFG_A = 8'h17;
    localparam logic [7:0] TRM_ADDR_PREAMBLE_CFG_B = 8'h18;
    localparam logic [7:0] TRM_ADDR_NOISE_THRESHOLD = 8'h19;
    localparam logic [7:0] TRM_ADDR_DETECTOR_CFG = 8'h1a;
    localparam logic [7:0] TRM_ADDR_COMPARATOR_CFG = 8'h1b;
    localparam logic [7:0] TRM_ADDR_PEAK_HOLD_CFG = 8'h1c;
    localparam logic [7:0] TRM_ADDR_SHUTDOWN_TIMER_CFG = 8'h1d;
    localparam logic [7:0] TRM_ADDR_DETECT_LOCK_STATUS = 8'h1e;
    localparam logic [7:0] TRM_ADDR_PEAK_LEVEL_STATUS = 8'h1f;
    localparam logic [7:0] TRM_ADDR_COMPARATOR_STATUS_A = 8'h20;
    localparam logic [7:0] TRM_ADDR_COMPARATOR_STATUS_B = 8'h21;
    localparam logic [7:0] TRM_ADDR_STRENGTH_LEVEL_STATUS = 8'h22;
    localparam logic [7:0] TRM_ADDR_NOISE_LEVEL_STATUS = 8'h23;

    // Reset value, soft reset pattern, general settings fields
    localparam logic [7:0] TRM_REG_INIT = 8'h00;
    localparam logic [7:0] TRM_SOFT_RESET_PATTERN = 8'h55;
    localparam int TRM_GEN_CHIP_ENABLE_BIT = 7;
    localparam int TRM_GEN_ACTIVITY_SELECT_BIT = 6;

    // Host request and answer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } trm_req_t;

    typedef struct packed {
        logic busy;
        logic wr_ack;
        logic wr_err;
        logic rd_valid;
        logic rd_err;
        logic [7:0] rd_data;
    } trm_rsp_t;

    // Live values from the radio
    typedef struct packed {
        logic [7:0] detect_lock;
        logic [7:0] peak_level;
        logic [7:0] comparator_a;
        logic [7:0] comparator_b;
        logic [7:0] strength_level;
        logic [7:0] noise_level;
    } trm_mon_t;

    typedef enum logic [1:0] {TRM_PWR_SLEEP, TRM_PWR_STANDBY, TRM_PWR_RUN} trm_pwr_t;

    typedef enum logic [1:0] {TRM_PH_IDLE, TRM_PH_RD_CFG, TRM_PH_RD_MON, TRM_PH_RD_BAD} trm_phase_t;

    // State of the register map apart from the stored configuration bytes
    typedef struct packed {
        trm_phase_t phase;
        trm_rsp_t rsp;
        logic [7:0] mon_hold;
        logic [7:0] general;
        logic [7:0] shutdown;
        trm_pwr_t pwr;
        logic soft_pulse;
    } trm_state_t;

    // Writable and readable configuration window for the current mode
    function automatic logic trm_cfg_open(input logic [7:0] addr, input logic self_load);
        if (self_load) begin
            return (addr >= TRM_ADDR_GENERAL_SETTINGS) && (addr <= TRM_ADDR_PEAK_HOLD_CFG);
        end
        return (addr >= TRM_ADDR_SOFT_RESET_KEY) && (addr <= TRM_ADDR_SHUTDOWN_TIMER_CFG);
    endfunction

    // Monitor window, reachable only in serial mode
    function automatic logic trm_mon_open(input logic [7:0] addr, input logic self_load);
        return !self_load && (addr >= TRM_ADDR_DETECT_LOCK_STATUS)
            && (addr <= TRM_ADDR_NOISE_LEVEL_STATUS);
    endfunction

    // Storage slot of a configuration address
    function automatic logic [TRM_IDX_W-1:0] trm_mem_idx(input logic [7:0] addr);
        logic [7:0] d;
        d = addr - TRM_ADDR_SOFT_RESET_KEY;
        return d[TRM_IDX_W-1:0];
    endfunction

endpackage

// ===== verilog/trm_reg_mem.sv
// Storage for the writable configuration bytes.
// Assumes the caller keeps the index below the depth.
`timescale 1ns/100ps
`default_nettype none

module trm_reg_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 21,
    parameter int IDX_W = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Access
    input wire logic clear,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [IDX_W-1:0] idx,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    import trm_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0] rdata;
    } trm_mem_state_t;

    trm_mem_state_t st;
    trm_mem_state_t next_st;

    // Clear beats a write; read returns the old byte
    always_comb begin
        next_st = st;
        if (rd_en && (int'(idx) < DEPTH)) begin
            next_st.rdata = st.cells[idx];
        end
        if (clear) begin
            next_st.cells = '0;
        end else if (wr_en && (int'(idx) < DEPTH)) begin
            next_st.cells[idx] = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rdata;

endmodule
`default_nettype wire

// ===== verilog/trm_register_map.sv
// Register map of the transceiver control interface.
// Assumes a host that offers one byte request at a time and waits
// for the answer of a read before the next request.
`timescale 1ns/100ps
`default_nettype none

module trm_register_map #(
    parameter int DEPTH = 21
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host register access
    input wire trm_pkg::trm_req_t host_req,
    output var trm_pkg::trm_rsp_t host_rsp,
    // Mode and pins
    input wire logic self_load_mode,
    input wire logic chip_enable_pin,
    input wire logic reset_pin_n,
    // Live monitor values
    input wire trm_pkg::trm_mon_t monitor,
    // Settings toward the radio
    output var trm_pkg::trm_pwr_t power_state,
    output logic [7:0] general_cfg,
    output logic [7:0] timed_auto_shutdown,
    output logic soft_reset_pulse
);
    import trm_pkg::*;

    trm_state_t st;
    trm_state_t next_st;

    // Storage port controls
    logic mem_clear;
    logic mem_wr;
    logic mem_rd;
    logic [TRM_IDX_W-1:0] mem_idx;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;

    // Decoded request
    logic cfg_hit;
    logic mon_hit;
    logic key_hit;

    // The configuration bytes live in their own storage
    trm_reg_mem #(
        .WIDTH(TRM_DATA_W),
        .DEPTH(DEPTH),
        .IDX_W(TRM_IDX_W)
    ) u_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(mem_clear),
        .wr_en(mem_wr),
        .rd_en(mem_rd),
        .idx(mem_idx),
        .wr_data(mem_wdata),
        .rd_data(mem_rdata)
    );

    // Address decode for the current mode
    always_comb begin
        cfg_hit = trm_cfg_open(host_req.addr, self_load_mode);
        mon_hit = trm_mon_open(host_req.addr, self_load_mode);
        key_hit = (host_req.addr == TRM_ADDR_SOFT_RESET_KEY)
            && (host_req.wdata == TRM_SOFT_RESET_PATTERN);
    end

    // Request handling, read sequencing and power state
    always_comb begin
        next_st = st;
        next_st.rsp.wr_ack = 1'b0;
        next_st.rsp.wr_err = 1'b0;
        next_st.rsp.rd_valid = 1'b0;
        next_st.rsp.rd_err = 1'b0;
        next_st.soft_pulse = 1'b0;
        mem_clear = 1'b0;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_idx = trm_mem_idx(host_req.addr);
        mem_wdata = host_req.wdata;

        case (st.phase)
            TRM_PH_IDLE: begin
                // A write wins over a read offered in the same cycle
                if (host_req.wr) begin
                    next_st.rsp.wr_ack = 1'b1;
                    if (!cfg_hit) begin
                        // Monitors and closed addresses keep their contents
                        next_st.rsp.wr_err = 1'b1;
                    end else if (key_hit) begin
                        // Every register back to its initial value
                        mem_clear = 1'b1;
                        next_st.general = TRM_REG_INIT;
                        next_st.shutdown = TRM_REG_INIT;
                        next_st.soft_pulse = 1'b1;
                    end else begin
                        mem_wr = 1'b1;
                        if (host_req.addr == TRM_ADDR_GENERAL_SETTINGS) begin
                            next_st.general = host_req.wdata;
                        end
                        if (host_req.addr == TRM_ADDR_SHUTDOWN_TIMER_CFG) begin
                            next_st.shutdown = host_req.wdata;
                        end
                    end
                end else if (host_req.rd) begin
                    next_st.rsp.busy = 1'b1;
                    if (cfg_hit) begin
                        mem_rd = 1'b1;
                        next_st.phase = TRM_PH_RD_CFG;
                    end else if (mon_hit) begin
                        next_st.phase = TRM_PH_RD_MON;
                        // Live value caught on the request edge
                        case (host_req.addr)
                            TRM_ADDR_DETECT_LOCK_STATUS: begin
                                next_st.mon_hold = monitor.detect_lock;
                            end
                            TRM_ADDR_PEAK_LEVEL_STATUS: begin
                                next_st.mon_hold = monitor.peak_level;
                            end
                            TRM_ADDR_COMPARATOR_STATUS_A: begin
                                next_st.mon_hold = monitor.comparator_a;
                            end
                            TRM_ADDR_COMPARATOR_STATUS_B: begin
                                next_st.mon_hold = monitor.comparator_b;
                            end
                            TRM_ADDR_STRENGTH_LEVEL_STATUS: begin
                                next_st.mon_hold = monitor.strength_level;
                            end
                            TRM_ADDR_NOISE_LEVEL_STATUS: begin
                                next_st.mon_hold = monitor.noise_level;
                            end
                            default: begin
                                next_st.mon_hold = TRM_REG_INIT;
                            end
                        endcase
                    end else begin
                        // Closed address: answered, flagged, reads zero
                        next_st.phase = TRM_PH_RD_BAD;
                    end
                end
            end
            TRM_PH_RD_CFG: begin
                // Storage output became valid on the request edge
                next_st.rsp.rd_valid = 1'b1;
                next_st.rsp.rd_data = mem_rdata;
                next_st.rsp.busy = 1'b0;
                next_st.phase = TRM_PH_IDLE;
            end
            TRM_PH_RD_MON: begin
                next_st.rsp.rd_valid = 1'b1;
                next_st.rsp.rd_data = st.mon_hold;
                next_st.rsp.busy = 1'b0;
                next_st.phase = TRM_PH_IDLE;
            end
            TRM_PH_RD_BAD: begin
                next_st.rsp.rd_valid = 1'b1;
                next_st.rsp.rd_err = 1'b1;
                next_st.rsp.rd_data = TRM_REG_INIT;
                next_st.rsp.busy = 1'b0;
                next_st.phase = TRM_PH_IDLE;
            end
            default: begin
                next_st.rsp.busy = 1'b0;
                next_st.phase = TRM_PH_IDLE;
            end
        endcase

        // Pins override the register bits; one cycle behind a write
        if (!chip_enable_pin || !reset_pin_n
                || !st.general[TRM_GEN_CHIP_ENABLE_BIT]) begin
            next_st.pwr = TRM_PWR_SLEEP;
        end else if (!st.general[TRM_GEN_ACTIVITY_SELECT_BIT]) begin
            next_st.pwr = TRM_PWR_STANDBY;
        end else begin
            next_st.pwr = TRM_PWR_RUN;
        end
    end

    // Single state register; sleep is the safe value out of reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign host_rsp = st.rsp;
    assign power_state = st.pwr;
    assign general_cfg = st.general;
    assign timed_auto_shutdown = st.shutdown;
    assign soft_reset_pulse = st.soft_pulse;

endmodule
`default_nettype wire

// ===== tb/trm_properties.sv
// Port checker for the transceiver register map.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module trm_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host port
    input wire trm_pkg::trm_req_t host_req,
    input wire trm_pkg::trm_rsp_t host_rsp,
    // Mode, pins and live values
    input wire logic self_load_mode,
    input wire logic chip_enable_pin,
    input wire logic reset_pin_n,
    input wire trm_pkg::trm_mon_t monitor,
    // Settings toward the radio
    input wire trm_pkg::trm_pwr_t power_state,
    input wire logic [7:0] general_cfg,
    input wire logic [7:0] timed_auto_shutdown,
    input wire logic soft_reset_pulse
);
    import trm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Requests the idle port takes; write beats read
    logic take_wr;
    logic take_rd;
    logic [7:0] wd;
    logic [7:0] lock_in;
    assign take_wr = !host_rsp.busy && host_req.wr;
    assign take_rd = !host_rsp.busy && host_req.rd && !host_req.wr;
    assign wd = host_req.wdata;
    assign lock_in = monitor.detect_lock;

    wr_answer_a: assert property (take_wr |=> host_rsp.wr_ack)
        else $error("write not answered");
    ro_refuse_a: assert property (take_wr && host_req.addr >= 8'h1e |=> host_rsp.wr_err)
        else $error("monitor write accepted");
    hidden_reg_a: assert property (take_wr && self_load_mode
        && (host_req.addr == 8'h09 || host_req.addr == 8'h1d) |=> host_rsp.wr_err)
        else $error("hidden register written");
    rd_timing_a: assert property (take_rd |=> host_rsp.busy ##1
        (host_rsp.rd_valid && !host_rsp.busy))
        else $error("read answer late");
    lock_read_a: assert property (take_rd && !self_load_mode && host_req.addr == 8'h1e
        |=> ##1 host_rsp.rd_data == $past(lock_in, 2))
        else $error("status byte wrong");
    closed_zero_a: assert property (host_rsp.rd_err
        |-> host_rsp.rd_valid && host_rsp.rd_data == 8'h00)
        else $error("closed read data");
    key_reset_a: assert property (take_wr && !self_load_mode && host_req.addr == 8'h09
        && wd == 8'h55 |=> soft_reset_pulse && general_cfg == 8'h00)
        else $error("key did not reset");
    gen_copy_a: assert property (take_wr && host_req.addr == 8'h0a
        |=> general_cfg == $past(wd))
        else $error("general copy stale");
    shut_copy_a: assert property (take_wr && !self_load_mode && host_req.addr == 8'h1d
        |=> timed_auto_shutdown == $past(wd))
        else $error("shutdown copy stale");
    sleep_sel_a: assert property (!chip_enable_pin || !reset_pin_n || !general_cfg[7]
        |=> power_state == TRM_PWR_SLEEP)
        else $error("sleep not entered");
endmodule
bind trm_register_map trm_properties trm_properties_inst (.clk(clk), .sys_rst(sys_rst),
    .host_req(host_req), .host_rsp(host_rsp), .self_load_mode(self_load_mode),
    .chip_enable_pin(chip_enable_pin), .reset_pin_n(reset_pin_n), .monitor(monitor),
    .power_state(power_state), .general_cfg(general_cfg),
    .timed_auto_shutdown(timed_auto_shutdown), .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

// ===== tb/trm_host_model.sv
// Host controller model offering one byte request at a time.
// Assumes callers enter its tasks at a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module trm_host_model (
    // Clock
    input wire logic clk,
    // Request out, answer in
    output var trm_pkg::trm_req_t req,
    input wire trm_pkg::trm_rsp_t rsp
);
    import trm_pkg::*;
    // Hold the request until an idle edge has taken it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        while (rsp.busy !== 1'b0) @(negedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
    endtask
    // Released lines flip, so stale values never look valid
    task automatic idle();
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
        @(negedge clk);
    endtask
    initial req = '0;
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the transceiver register map.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import trm_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic self_load_mode = 1'b0;
    logic chip_enable_pin = 1'b0;
    logic reset_pin_n = 1'b0;
    trm_mon_t monitor = '0;
    trm_req_t host_req;
    trm_rsp_t host_rsp;
    trm_pwr_t power_state;
    logic [7:0] general_cfg;
    logic [7:0] timed_auto_shutdown;
    logic soft_reset_pulse;
    int fails = 0;
    int n_checks = 0;
    int seed = 32'hf741adaf;
    logic [7:0] shadow [0:255];
    logic [9:0] exp_q [$];
    logic [11:0] pw [0:4] = '{12'hf02, 12'he01, 12'h700, 12'hb00, 12'hd00};
    logic [63:0] r64;
    logic [7:0] d;

    always #5 clk = ~clk;

    trm_register_map #(.DEPTH(21)) trm_register_map_inst (.clk(clk), .sys_rst(sys_rst),
        .host_req(host_req), .host_rsp(host_rsp), .self_load_mode(self_load_mode),
        .chip_enable_pin(chip_enable_pin), .reset_pin_n(reset_pin_n), .monitor(monitor),
        .power_state(power_state), .general_cfg(general_cfg),
        .timed_auto_shutdown(timed_auto_shutdown), .soft_reset_pulse(soft_reset_pulse));
    trm_host_model trm_host_model_inst (.clk(clk), .req(host_req), .rsp(host_rsp));

    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Note the owed answer, update the shadow copy, then issue
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
        logic open;
        logic [7:0] rv;
        open = self_load_mode ? (a >= 8'h0a && a <= 8'h1c)
            : (a >= 8'h09 && a <= (w ? 8'h1d : 8'h23));
        if (!w) begin
            r64 = {$random(seed), $random(seed)};
            monitor = r64[47:0];
        end
        rv = (a >= 8'h1e) ? monitor[8 * (5 - int'(a - 8'h1e)) +: 8] : shadow[a];
        if (w && open) shadow[a] = wd;
        if (w && open && a == 8'h09 && wd == 8'h55) begin
            foreach (shadow[i]) shadow[i] = 8'h00;
        end
        exp_q.push_back({!w, !open, (w || !open) ? 8'h00 : rv});
        trm_host_model_inst.xfer(w, a, wd);
    endtask

    // Sweep 08..24 with random bytes, then read it all back
    task automatic sweep();
        for (int a = 8'h08; a <= 8'h24; a++) begin
            d = $random(seed);
            if (a == 9 && d == 8'h55) d = 8'h54;
            acc(1'b1, 8'(a), d);
        end
        for (int a = 8'h08; a <= 8'h24; a++) acc(1'b0, 8'(a), 8'h00);
        repeat (3) trm_host_model_inst.idle();
    endtask

    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Answers are compared oldest note first
    always @(negedge clk) begin
        if (!sys_rst && (host_rsp.wr_ack === 1'b1 || host_rsp.rd_valid === 1'b1)) begin
            check("answer", exp_q.size() ? exp_q.pop_front() : 10'h3ff, {host_rsp.rd_valid,
                host_rsp.rd_err | host_rsp.wr_err, host_rsp.rd_valid ? host_rsp.rd_data : 8'h00});
        end
    end

    // Whole run is a few hundred cycles; this allows far more
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    initial begin
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        chip_enable_pin = 1'b1;
        reset_pin_n = 1'b1;
        @(negedge clk);
        for (int a = 8'h08; a <= 8'h24; a++) acc(1'b0, 8'(a), 8'h00);
        sweep();
        acc(1'b1, 8'hff, 8'h3c);
        acc(1'b0, 8'hff, 8'h00);
        self_load_mode = 1'b1;
        sweep();
        self_load_mode = 1'b0;
        sweep();
        // Power selection by pins and the general settings byte
        foreach (pw[i]) begin
            {chip_enable_pin, reset_pin_n} = pw[i][11:10];
            acc(1'b1, 8'h0a, pw[i][9:2]);
            trm_host_model_inst.idle();
            check("power", {8'h00, pw[i][1:0]}, {8'h00, power_state});
        end
        acc(1'b1, 8'h09, 8'h55);
        for (int a = 8'h09; a <= 8'h1d; a++) acc(1'b0, 8'(a), 8'h00);
        repeat (4) trm_host_model_inst.idle();
        check("leftover", 10'h000, 10'(exp_q.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire
